/* File: mgmt_mux_pkg.sv */
// constants and types for the port 0 management path mux
package mgmt_mux_pkg;
    // management mode straps: bit 1 = two-wire managed, bit 0 = phy mode
    localparam int MODE_W = 2;
    localparam logic [1:0] MODE_MAC_SERIAL = 2'h0;
    localparam logic [1:0] MODE_PHY_SERIAL = 2'h1;
    localparam logic [1:0] MODE_MAC_TWI = 2'h2;
    localparam logic [1:0] MODE_PHY_TWI = 2'h3;
    localparam logic [1:0] MODE_RESET = 2'h1;
    // upstream parallel-interface owners
    localparam logic [1:0] PAR_LOADER = 2'h0;
    localparam logic [1:0] PAR_SERIAL = 2'h1;
    localparam logic [1:0] PAR_TWI = 2'h2;
    localparam logic [1:0] PAR_NONE = 2'h3;
    // read data source select codes
    localparam logic [2:0] RD_NONE = 3'h0;
    localparam logic [2:0] RD_PHY_A = 3'h1;
    localparam logic [2:0] RD_PHY_B = 3'h2;
    localparam logic [2:0] RD_VPHY = 3'h3;
    localparam logic [2:0] RD_SLAVE = 3'h4;
    localparam logic [2:0] RD_PIN = 3'h5;
    typedef enum logic [1:0] {ST_STRAP, ST_INIT, ST_RUN} phase_t;
endpackage : mgmt_mux_pkg

/* File: mgmt_route_table.sv */
// routing decode for management mode and phase
`timescale 1ns/1ns
module mgmt_route_table
    import mgmt_mux_pkg::*;
(
    // selection
    input wire logic [1:0] mode_in,
    input wire logic init_in,
    // routing
    output logic phys_from_pin_out,
    output logic vphy_from_pin_out,
    output logic slave_from_pin_out,
    output logic iface_drives_pin_out,
    output logic [1:0] iface_par_owner_out,
    output logic [1:0] vphy_par_owner_out
);
    always_comb
    begin
        phys_from_pin_out = 1'b0;
        vphy_from_pin_out = 1'b0;
        slave_from_pin_out = 1'b0;
        iface_drives_pin_out = 1'b0;
        iface_par_owner_out = PAR_LOADER;
        vphy_par_owner_out = PAR_LOADER;
        case (mode_in)
            MODE_PHY_SERIAL:
            begin
                vphy_from_pin_out = 1'b1;
                slave_from_pin_out = 1'b1;
                if (init_in)
                begin
                    phys_from_pin_out = 1'b0;
                    iface_par_owner_out = PAR_LOADER;
                    vphy_par_owner_out = PAR_LOADER;
                end
                else
                begin
                    phys_from_pin_out = 1'b1;
                    iface_par_owner_out = PAR_SERIAL;
                    vphy_par_owner_out = PAR_SERIAL;
                end
            end
            MODE_MAC_SERIAL:
            begin
                slave_from_pin_out = 1'b1;
                phys_from_pin_out = !init_in;
                iface_par_owner_out = init_in ? PAR_LOADER : PAR_SERIAL;
                vphy_par_owner_out = init_in ? PAR_LOADER : PAR_SERIAL;
            end
            MODE_MAC_TWI:
            begin
                iface_drives_pin_out = 1'b1;
                iface_par_owner_out = init_in ? PAR_LOADER : PAR_TWI;
                vphy_par_owner_out = init_in ? PAR_LOADER : PAR_SERIAL;
            end
            default:
            begin
                vphy_from_pin_out = 1'b1;
                iface_par_owner_out = init_in ? PAR_LOADER : PAR_TWI;
                vphy_par_owner_out = init_in ? PAR_LOADER : PAR_TWI;
            end
        endcase
    end
endmodule : mgmt_route_table

/* File: port0_mgmt_path_mux.sv */
// port 0 management path multiplexer
`timescale 1ns/1ns
module port0_mgmt_path_mux
    import mgmt_mux_pkg::*;
(
    // clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // configuration
    input wire logic [1:0] mode_strap_in,
    input wire logic loader_done_in,
    // port 0 management pins
    input wire logic pin_mdc_in,
    input wire logic pin_mdio_in,
    output logic pin_mdc_out,
    output logic pin_mdc_oe_out,
    output logic pin_mdio_out,
    output logic pin_mdio_oe_out,
    // internal phy_mgmt_iface master
    input wire logic iface_mdc_in,
    input wire logic iface_mdio_in,
    input wire logic iface_mdio_oe_in,
    output logic iface_mdio_out,
    // slaves: serial data out and drive request
    input wire logic phy_a_mdio_in,
    input wire logic phy_a_oe_in,
    input wire logic phy_b_mdio_in,
    input wire logic phy_b_oe_in,
    input wire logic vphy_mdio_in,
    input wire logic vphy_oe_in,
    input wire logic slave_mdio_in,
    input wire logic slave_oe_in,
    // management clock and data to slaves
    output logic phys_mdc_out,
    output logic phys_mdio_out,
    output logic vphy_mdc_out,
    output logic vphy_mdio_out,
    output logic slave_mdc_out,
    output logic slave_mdio_out,
    // parallel register owner selects
    output logic [1:0] iface_par_owner_out,
    output logic [1:0] vphy_par_owner_out,
    // status
    output logic init_active_out,
    output logic [1:0] mode_out
);
    phase_t phase_reg, phase_next;
    logic [1:0] mode_reg, mode_next;
    logic phys_pin, vphy_pin, slave_pin, iface_pin;
    logic [1:0] iface_own, vphy_own;
    logic [2:0] rd_sel;
    logic rd_bit, rd_oe;
    logic pin_mdc_oe_next, pin_mdc_next, pin_mdio_oe_next, pin_mdio_next;
    logic phys_mdc_next, phys_mdio_next, vphy_mdc_next, vphy_mdio_next;
    logic slave_mdc_next, slave_mdio_next, iface_mdio_next, init_active_next;
    logic pin_mdc_oe_reg, pin_mdc_reg, pin_mdio_oe_reg, pin_mdio_reg;
    logic phys_mdc_reg, phys_mdio_reg, vphy_mdc_reg, vphy_mdio_reg;
    logic slave_mdc_reg, slave_mdio_reg, iface_mdio_reg, init_active_reg;
    logic [1:0] iface_own_reg, vphy_own_reg;

    mgmt_route_table route_u (
        .mode_in(mode_reg),
        .init_in(phase_reg != ST_RUN),
        .phys_from_pin_out(phys_pin),
        .vphy_from_pin_out(vphy_pin),
        .slave_from_pin_out(slave_pin),
        .iface_drives_pin_out(iface_pin),
        .iface_par_owner_out(iface_own),
        .vphy_par_owner_out(vphy_own)
    );

    // mode capture and init phase
    always_comb
    begin
        phase_next = phase_reg;
        mode_next = mode_reg;
        case (phase_reg)
            ST_STRAP:
            begin
                mode_next = mode_strap_in;
                phase_next = ST_INIT;
            end
            ST_INIT:
            begin
                if (loader_done_in)
                begin
                    phase_next = ST_RUN;
                end
            end
            default:
            begin
                phase_next = ST_RUN;
            end
        endcase
        init_active_next = (phase_next != ST_RUN);
    end

    // read data source: one at most
    always_comb
    begin
        rd_sel = RD_NONE;
        if (iface_pin)
        begin
            rd_sel = RD_PIN;
        end
        else if (phys_pin && phy_a_oe_in)
        begin
            rd_sel = RD_PHY_A;
        end
        else if (phys_pin && phy_b_oe_in)
        begin
            rd_sel = RD_PHY_B;
        end
        else if (vphy_pin && vphy_oe_in)
        begin
            rd_sel = RD_VPHY;
        end
        else if (slave_pin && slave_oe_in)
        begin
            rd_sel = RD_SLAVE;
        end
    end

    always_comb
    begin
        rd_bit = 1'b1;
        rd_oe = 1'b0;
        case (rd_sel)
            RD_PHY_A:
            begin
                rd_bit = phy_a_mdio_in;
                rd_oe = 1'b1;
            end
            RD_PHY_B:
            begin
                rd_bit = phy_b_mdio_in;
                rd_oe = 1'b1;
            end
            RD_VPHY:
            begin
                rd_bit = vphy_mdio_in;
                rd_oe = 1'b1;
            end
            RD_SLAVE:
            begin
                rd_bit = slave_mdio_in;
                rd_oe = 1'b1;
            end
            default:
            begin
                rd_bit = 1'b1;
                rd_oe = 1'b0;
            end
        endcase
    end

    // pin and slave drive
    always_comb
    begin
        pin_mdc_oe_next = iface_pin;
        pin_mdc_next = iface_pin ? iface_mdc_in : 1'b0;
        pin_mdio_oe_next = iface_pin ? iface_mdio_oe_in : rd_oe;
        pin_mdio_next = iface_pin ? iface_mdio_in : rd_bit;
        phys_mdc_next = phys_pin ? pin_mdc_in : iface_mdc_in;
        phys_mdio_next = phys_pin ? pin_mdio_in : iface_mdio_in;
        vphy_mdc_next = vphy_pin ? pin_mdc_in : 1'b0;
        vphy_mdio_next = vphy_pin ? pin_mdio_in : 1'b1;
        slave_mdc_next = slave_pin ? pin_mdc_in : 1'b0;
        slave_mdio_next = slave_pin ? pin_mdio_in : 1'b1;
        if (iface_pin)
        begin
            iface_mdio_next = pin_mdio_in;
        end
        else if (phy_a_oe_in)
        begin
            iface_mdio_next = phy_a_mdio_in;
        end
        else if (phy_b_oe_in)
        begin
            iface_mdio_next = phy_b_mdio_in;
        end
        else
        begin
            iface_mdio_next = 1'b1;
        end
    end

    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            phase_reg <= ST_STRAP;
            mode_reg <= MODE_RESET;
            pin_mdc_oe_reg <= 1'b0;
            pin_mdc_reg <= 1'b0;
            pin_mdio_oe_reg <= 1'b0;
            pin_mdio_reg <= 1'b1;
            phys_mdc_reg <= 1'b0;
            phys_mdio_reg <= 1'b1;
            vphy_mdc_reg <= 1'b0;
            vphy_mdio_reg <= 1'b1;
            slave_mdc_reg <= 1'b0;
            slave_mdio_reg <= 1'b1;
            iface_mdio_reg <= 1'b1;
            init_active_reg <= 1'b1;
            iface_own_reg <= PAR_NONE;
            vphy_own_reg <= PAR_NONE;
        end
        else
        begin
            phase_reg <= phase_next;
            mode_reg <= mode_next;
            pin_mdc_oe_reg <= pin_mdc_oe_next;
            pin_mdc_reg <= pin_mdc_next;
            pin_mdio_oe_reg <= pin_mdio_oe_next;
            pin_mdio_reg <= pin_mdio_next;
            phys_mdc_reg <= phys_mdc_next;
            phys_mdio_reg <= phys_mdio_next;
            vphy_mdc_reg <= vphy_mdc_next;
            vphy_mdio_reg <= vphy_mdio_next;
            slave_mdc_reg <= slave_mdc_next;
            slave_mdio_reg <= slave_mdio_next;
            iface_mdio_reg <= iface_mdio_next;
            init_active_reg <= init_active_next;
            iface_own_reg <= (phase_reg == ST_STRAP) ? PAR_NONE : iface_own;
            vphy_own_reg <= (phase_reg == ST_STRAP) ? PAR_NONE : vphy_own;
        end
    end

    assign pin_mdc_oe_out = pin_mdc_oe_reg;
    assign pin_mdc_out = pin_mdc_reg;
    assign pin_mdio_oe_out = pin_mdio_oe_reg;
    assign pin_mdio_out = pin_mdio_reg;
    assign phys_mdc_out = phys_mdc_reg;
    assign phys_mdio_out = phys_mdio_reg;
    assign vphy_mdc_out = vphy_mdc_reg;
    assign vphy_mdio_out = vphy_mdio_reg;
    assign slave_mdc_out = slave_mdc_reg;
    assign slave_mdio_out = slave_mdio_reg;
    assign iface_mdio_out = iface_mdio_reg;
    assign iface_par_owner_out = iface_own_reg;
    assign vphy_par_owner_out = vphy_own_reg;
    assign init_active_out = init_active_reg;
    assign mode_out = mode_reg;

    // checks
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!reset_n_in);

    init_phys_a: assert property ((phase_reg == ST_INIT && mode_reg == MODE_PHY_SERIAL)
        |=> phys_mdc_out == $past(iface_mdc_in)) else $error("phys not on iface in init");
    run_phys_a: assert property ((phase_reg == ST_RUN && mode_reg == MODE_PHY_SERIAL)
        |=> phys_mdio_out == $past(pin_mdio_in)) else $error("phys not on pins");
    init_vphy_a: assert property ((phase_reg == ST_INIT && mode_reg == MODE_PHY_SERIAL)
        |=> vphy_mdc_out == $past(pin_mdc_in)) else $error("vphy lost in init");
    init_owner_a: assert property ((phase_reg == ST_INIT && mode_reg == MODE_PHY_SERIAL)
        |=> iface_par_owner_out == PAR_LOADER && vphy_par_owner_out == PAR_LOADER)
        else $error("init owner wrong");
    run_owner_a: assert property ((phase_reg == ST_RUN && mode_reg == MODE_PHY_SERIAL)
        |=> vphy_par_owner_out == PAR_SERIAL && iface_par_owner_out == PAR_SERIAL)
        else $error("run owner wrong");
    twi_owner_a: assert property ((phase_reg == ST_RUN && mode_reg[1])
        |=> iface_par_owner_out == PAR_TWI) else $error("twi owner wrong");
    mac_twi_pin_a: assert property ((mode_reg == MODE_MAC_TWI && phase_reg != ST_STRAP)
        |=> pin_mdc_oe_out && pin_mdc_out == $past(iface_mdc_in))
        else $error("iface not on pins");
    mdio_drive_a: assert property (pin_mdio_oe_out |-> $past(iface_pin || rd_oe))
        else $error("pin driven without cause");
    phy_twi_vphy_a: assert property ((phase_reg != ST_STRAP && mode_reg == MODE_PHY_TWI)
        |=> vphy_mdio_out == $past(pin_mdio_in) && !pin_mdc_oe_out)
        else $error("vphy not on pins");
    run_after_done_a: assert property ((phase_reg == ST_INIT && loader_done_in)
        |=> phase_reg == ST_RUN ##1 phase_reg == ST_RUN) else $error("init not ended");
    mode_hold_a: assert property (phase_reg != ST_STRAP |=> $stable(mode_reg))
        else $error("mode changed");

    init_end_c: cover property (phase_reg == ST_INIT ##1 phase_reg == ST_RUN);
    slave_read_c: cover property (rd_sel == RD_SLAVE ##1 pin_mdio_oe_out);
    mac_twi_c: cover property (mode_reg == MODE_MAC_TWI && phase_reg == ST_RUN);
    phy_read_c: cover property (rd_sel == RD_PHY_A);
endmodule : port0_mgmt_path_mux

/* File: mgmt_station_model.sv */
// external management station on the port 0 pins, with wire resolution
`timescale 1ns/1ns
module mgmt_station_model
(
    // station commands from the bench
    input wire logic drive_en_in,
    input wire logic mdc_cmd_in,
    input wire logic mdio_cmd_in,
    // device pin drivers
    input wire logic dev_mdc_in,
    input wire logic dev_mdc_oe_in,
    input wire logic dev_mdio_in,
    input wire logic dev_mdio_oe_in,
    // resolved pin levels
    output logic wire_mdc_out,
    output logic wire_mdio_out
);
    // clock stands still low when nobody drives it
    assign wire_mdc_out = dev_mdc_oe_in ? dev_mdc_in : (drive_en_in & mdc_cmd_in);
    // data line has a pull-up when released
    assign wire_mdio_out = dev_mdio_oe_in ? dev_mdio_in
                         : (drive_en_in ? mdio_cmd_in : 1'b1);
endmodule : mgmt_station_model

/* File: testbench.sv */
// self-checking testbench for the port 0 management path mux
`timescale 1ns/1ns
module testbench;
    import mgmt_mux_pkg::*;
    localparam logic [1:0] IDLE = 2'h1;
    localparam logic [1:0] PIN = 2'h2;
    localparam logic [1:0] IFC = 2'h0;
    logic clk = 1'b0, rst_n = 1'b0, done = 1'b0;
    logic [1:0] mode = MODE_PHY_SERIAL;
    logic i_mdc = 1'b0, i_mdio = 1'b1, i_oe = 1'b0;
    logic a_d = 1'b1, a_oe = 1'b0, b_d = 1'b1, b_oe = 1'b0;
    logic v_d = 1'b1, v_oe = 1'b0, s_d = 1'b1, s_oe = 1'b0;
    logic st_en = 1'b0, st_mdc = 1'b0, st_mdio = 1'b1;
    logic w_mdc, w_mdio, p_mdc, p_mdc_oe, p_mdio, p_mdio_oe, i_rd;
    logic ph_mdc, ph_mdio, v_mdc, v_mdio, s_mdc, s_mdio, init_act;
    logic [1:0] own_i, own_v, mode_o;
    int n_mismatch = 0;
    int num_checks = 0;

    mgmt_station_model u_mgmt_station_model (.drive_en_in(st_en), .mdc_cmd_in(st_mdc),
        .mdio_cmd_in(st_mdio), .dev_mdc_in(p_mdc), .dev_mdc_oe_in(p_mdc_oe),
        .dev_mdio_in(p_mdio), .dev_mdio_oe_in(p_mdio_oe), .wire_mdc_out(w_mdc),
        .wire_mdio_out(w_mdio));

    port0_mgmt_path_mux u_port0_mgmt_path_mux (.core_clk_in(clk), .reset_n_in(rst_n),
        .mode_strap_in(mode), .loader_done_in(done), .pin_mdc_in(w_mdc),
        .pin_mdio_in(w_mdio), .pin_mdc_out(p_mdc), .pin_mdc_oe_out(p_mdc_oe),
        .pin_mdio_out(p_mdio), .pin_mdio_oe_out(p_mdio_oe), .iface_mdc_in(i_mdc),
        .iface_mdio_in(i_mdio), .iface_mdio_oe_in(i_oe), .iface_mdio_out(i_rd),
        .phy_a_mdio_in(a_d), .phy_a_oe_in(a_oe), .phy_b_mdio_in(b_d), .phy_b_oe_in(b_oe),
        .vphy_mdio_in(v_d), .vphy_oe_in(v_oe), .slave_mdio_in(s_d), .slave_oe_in(s_oe),
        .phys_mdc_out(ph_mdc), .phys_mdio_out(ph_mdio), .vphy_mdc_out(v_mdc),
        .vphy_mdio_out(v_mdio), .slave_mdc_out(s_mdc), .slave_mdio_out(s_mdio),
        .iface_par_owner_out(own_i), .vphy_par_owner_out(own_v),
        .init_active_out(init_act), .mode_out(mode_o));

    initial
    begin
        forever #50 clk = ~clk;
    end

    task chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task end_of_test;
        if (n_mismatch == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test

    // reset with a given strap, then let mode and owners settle
    task rst(input logic [1:0] m);
        @(posedge clk);
        rst_n <= 1'b0;
        mode <= m;
        repeat (12) @(posedge clk);
        #1;
        chk({p_mdc_oe, p_mdio_oe, init_act, own_i, own_v}, 8'h1F);
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk(mode_o, m);
    endtask : rst

    // pins and internal master driven with distinct clock levels, both data lines low
    task probe;
        @(posedge clk);
        st_en <= 1'b1;
        st_mdc <= 1'b1;
        st_mdio <= 1'b0;
        i_mdc <= 1'b0;
        i_mdio <= 1'b0;
        @(posedge clk);
        #1;
    endtask : probe

    task finish_init;
        @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask : finish_init

    // set slave read drivers and look one cycle later
    task rd(input logic [7:0] drv, input logic [7:0] exp);
        @(posedge clk);
        {a_oe, a_d, b_oe, b_d, v_oe, v_d, s_oe, s_d} <= drv;
        @(posedge clk);
        #1;
        chk({p_mdio_oe, p_mdio & p_mdio_oe}, exp);
    endtask : rd

    task t_phy_serial;
        rst(MODE_PHY_SERIAL);
        probe;
        chk({ph_mdc, ph_mdio}, IFC);
        chk({v_mdc, v_mdio, s_mdc, s_mdio}, {PIN, PIN});
        chk({init_act, own_i, own_v}, {1'b1, PAR_LOADER, PAR_LOADER});
        @(posedge clk);
        done <= 1'b1;
        @(posedge clk);
        done <= 1'b0;
        #1;
        chk({init_act, own_i, own_v}, {1'b0, PAR_LOADER, PAR_LOADER});
        @(posedge clk);
        #1;
        chk({own_i, own_v}, {PAR_SERIAL, PAR_SERIAL});
        probe;
        chk({ph_mdc, ph_mdio, v_mdc, v_mdio, s_mdc, s_mdio}, {PIN, PIN, PIN});
        @(posedge clk);
        mode <= MODE_MAC_TWI;
        repeat (3) @(posedge clk);
        #1;
        chk(mode_o, MODE_PHY_SERIAL);
        rd(8'h02, 8'h02);
        rd(8'hC2, 8'h03);
        rd(8'h00, 8'h00);
    endtask : t_phy_serial

    task t_mac_twi;
        rst(MODE_MAC_TWI);
        finish_init;
        chk({own_i, own_v}, {PAR_TWI, PAR_SERIAL});
        probe;
        chk({ph_mdc, ph_mdio}, IFC);
        chk(i_rd, 1'b0);
        @(posedge clk);
        st_mdio <= 1'b1;
        i_oe <= 1'b1;
        i_mdc <= 1'b1;
        @(posedge clk);
        #1;
        chk(i_rd, 1'b1);
        chk({p_mdc_oe, p_mdc, p_mdio_oe, p_mdio}, 8'h0E);
        @(posedge clk);
        i_oe <= 1'b0;
        i_mdc <= 1'b0;
    endtask : t_mac_twi

    task t_phy_twi;
        rst(MODE_PHY_TWI);
        finish_init;
        chk({own_i, own_v}, {PAR_TWI, PAR_TWI});
        probe;
        chk({ph_mdc, ph_mdio, v_mdc, v_mdio}, {IFC, PIN});
        chk({p_mdc_oe, p_mdio_oe}, 8'h00);
        rd(8'h08, 8'h02);
        rd(8'h80, 8'h00);
        chk(i_rd, 1'b0);
        rd(8'h00, 8'h00);
    endtask : t_phy_twi

    task t_mac_serial;
        rst(MODE_MAC_SERIAL);
        probe;
        chk({ph_mdc, ph_mdio, s_mdc, s_mdio, v_mdc, v_mdio}, {IFC, PIN, IDLE});
        finish_init;
        chk({own_i, own_v}, {PAR_SERIAL, PAR_SERIAL});
        probe;
        chk({ph_mdc, ph_mdio, p_mdc_oe, p_mdio_oe}, {PIN, 2'h0});
    endtask : t_mac_serial

    initial
    begin
        #(100 * 2000);
        n_mismatch++;
        end_of_test;
    end

    initial
    begin
        t_phy_serial;
        t_mac_twi;
        t_phy_twi;
        t_mac_serial;
        end_of_test;
    end
endmodule : testbench
